//--- irq_pkg.sv
/*
  Shared constants and carriers for the vectored interrupt priority unit:
  register offsets, field positions, reset values, vector addresses.
  Assumes an AXI4-Lite master with 32-bit data and one system clock.
*/
package irq_pkg;

  // ---------------------------------------------------------------
  // Source counts
  // ---------------------------------------------------------------
  localparam int NUM_MASKABLE = 12;               // Maskable sources
  localparam int NUM_SOURCES  = 13;               // Including the NMI

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;      // Global enable, watchdog route
  localparam logic [7:0] OFS_EDGE   = 8'h04;      // Pin edge selection
  localparam logic [7:0] OFS_REQ    = 8'h08;      // Request flags, write one clears
  localparam logic [7:0] OFS_MASK   = 8'h0C;      // Mask flags, one masks
  localparam logic [7:0] OFS_VECTOR = 8'h10;      // Current vector, read only
  localparam logic [7:0] OFS_ACK    = 8'h14;      // Acknowledge / end of service
  localparam logic [7:0] OFS_STAT   = 8'h18;      // Sticky event status, W1C
  localparam logic [7:0] OFS_IMASK  = 8'h1C;      // Interrupt-line mask

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_GIE_BIT  = 0;               // Global enable flag
  localparam int CTRL_WDNM_BIT = 1;               // 1: watchdog is non-maskable
  localparam int ACK_TAKE_BIT  = 0;               // Take the pending vector
  localparam int ACK_RETI_BIT  = 1;               // Leave NMI service
  localparam int VEC_VALID_BIT = 31;              // Vector field is valid
  localparam int VEC_NMI_BIT   = 30;              // Pending one is the NMI
  localparam int VEC_SVC_BIT   = 29;              // NMI in service

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  CTRL_RESET = 2'h2;      // Enable off, watchdog NMI
  localparam logic [11:0] MASK_RESET = 12'hFFF;   // All sources masked
  localparam logic [3:0]  EDGE_RESET = 4'h0;      // Both pins rising

  // Edge select codes per pin
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // Vector table, index is priority level
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_TABLE [NUM_MASKABLE] = '{
    16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E,
    16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A};

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Internal peripheral pulses that share one clock
  typedef struct packed {
    logic watchdog_overflow_irq;
    logic remote_overflow_irq;
    logic key_scan_irq;
    logic serial_done_irq;
    logic timer_a_match_irq;
    logic timer_b_match_irq;
    logic watch_main_irq;
    logic watch_interval_irq;
  } periph_evt_s;

endpackage

//--- vectored_interrupt_priority_unit.sv
/*
  Vectored interrupt priority unit: thirteen sources, fixed priority,
  vector output toward the core, AXI4-Lite register access.
  Assumes peripheral pulses are on aclk; pins come from outside and are
  synchronised here.
*/
// Function
// - Thirteen sources: one NMI, twelve maskable
// - Watchdog mode 1 overflow raises NMI 0004H
// - Interval mode overflow is maskable level 0
// - Pin edges: a level 1 0006H, b 0008H
// - Remote input rising edge: level 3, 000AH
// - Remote input falling edge: level 4, 000CH
// - Remote timer overflow: level 5, 000EH
// - Key scan pulse: level 6, 0010H
// - Serial transfer done: level 7, 0012H
// - First timer match: level 8, 0014H
// - Second timer match: level 9, 0016H
// - Watch main interrupt: level 10, 0018H
// - Watch interval interrupt: level 11, 001AH
// - Simultaneous maskables served lowest level first
// - Software routes watchdog to NMI or maskable
// - Request and mask per source, global enable
// - Pins a and b detect rising, falling or both edges
module vectored_interrupt_priority_unit (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire irq_pkg::periph_evt_s periph_evt,
  input  wire logic                 ext_pin_a,
  input  wire logic                 ext_pin_b,
  input  wire logic                 remote_pin,
  output logic                      irq_pending,
  output logic                      nmi_pending,
  output logic [15:0]               vector_addr,
  output logic                      irq
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync_a, sync_b, sync_r;             // Three-stage chains
  logic       last_a, last_b, last_r;             // Last accepted level
  logic [2:0] next_sync_a, next_sync_b, next_sync_r;
  logic       next_last_a, next_last_b, next_last_r;
  logic       stable_a, stable_b, stable_r;       // Stages 2 and 3 agree
  logic       rise_a, fall_a, rise_b, fall_b, rise_r, fall_r;
  logic [1:0] fill_cnt, next_fill_cnt;            // Cycles since reset, stops at full
  logic       primed;                             // Chains hold real samples

  // Shift pins in; a change counts once the late stages agree
  always_comb begin
    next_sync_a = {sync_a[1:0], ext_pin_a};
    next_sync_b = {sync_b[1:0], ext_pin_b};
    next_sync_r = {sync_r[1:0], remote_pin};
    stable_a    = sync_a[1] == sync_a[2];
    stable_b    = sync_b[1] == sync_b[2];
    stable_r    = sync_r[1] == sync_r[2];
    // Until the chains are full, follow them silently so that a pin
    // idling high gives no false edge after reset
    primed        = fill_cnt == 2'h3;
    next_fill_cnt = primed ? fill_cnt : fill_cnt + 2'h1;
    next_last_a = !primed ? sync_a[1] : (stable_a ? sync_a[2] : last_a);
    next_last_b = !primed ? sync_b[1] : (stable_b ? sync_b[2] : last_b);
    next_last_r = !primed ? sync_r[1] : (stable_r ? sync_r[2] : last_r);
    rise_a = primed & stable_a & sync_a[2] & ~last_a;
    fall_a = primed & stable_a & ~sync_a[2] & last_a;
    rise_b = primed & stable_b & sync_b[2] & ~last_b;
    fall_b = primed & stable_b & ~sync_b[2] & last_b;
    rise_r = primed & stable_r & sync_r[2] & ~last_r;
    fall_r = primed & stable_r & ~sync_r[2] & last_r;
  end

  // Register synchroniser state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sync_r <= 3'h0;
      last_a <= 1'b0;
      last_b <= 1'b0;
      last_r <= 1'b0;
      fill_cnt <= 2'h0;
    end else begin
      fill_cnt <= next_fill_cnt;
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_r <= next_sync_r;
      last_a <= next_last_a;
      last_b <= next_last_b;
      last_r <= next_last_r;
    end
  end

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  logic [1:0]  ctrl;                              // Enable, watchdog route
  logic [3:0]  edge_sel;                          // Two bits per pin
  logic [11:0] req;                               // Request flags
  logic [11:0] mask_flag;                         // Mask flags
  logic        nmi_req;                           // NMI request
  logic        nmi_in_service_flag;               // NMI being served
  logic [3:0]  stat;                              // Sticky events
  logic [3:0]  imask;                             // Line mask
  logic        global_enable_flag;
  logic        wd_is_nmi;
  logic [11:0] raw_evt;                           // Per-level triggers
  logic        pin_a_hit, pin_b_hit;

  assign global_enable_flag = ctrl[irq_pkg::CTRL_GIE_BIT];
  assign wd_is_nmi          = ctrl[irq_pkg::CTRL_WDNM_BIT];

  // Edge qualification per selected mode
  function automatic logic pin_hit(input logic [1:0] sel, input logic r, input logic f);
    logic res;
    res = 1'b0;
    case (sel)
      irq_pkg::EDGE_RISE: res = r;
      irq_pkg::EDGE_FALL: res = f;
      irq_pkg::EDGE_BOTH: res = r | f;
      default:            res = 1'b0;
    endcase
    return res;
  endfunction

  assign pin_a_hit = pin_hit(edge_sel[1:0], rise_a, fall_a);
  assign pin_b_hit = pin_hit(edge_sel[3:2], rise_b, fall_b);

  // Map sources onto priority levels 0..11
  always_comb begin
    raw_evt[0]  = periph_evt.watchdog_overflow_irq & ~wd_is_nmi;
    raw_evt[1]  = pin_a_hit;
    raw_evt[2]  = pin_b_hit;
    raw_evt[3]  = rise_r;
    raw_evt[4]  = fall_r;
    raw_evt[5]  = periph_evt.remote_overflow_irq;
    raw_evt[6]  = periph_evt.key_scan_irq;
    raw_evt[7]  = periph_evt.serial_done_irq;
    raw_evt[8]  = periph_evt.timer_a_match_irq;
    raw_evt[9]  = periph_evt.timer_b_match_irq;
    raw_evt[10] = periph_evt.watch_main_irq;
    raw_evt[11] = periph_evt.watch_interval_irq;
  end

  // ---------------------------------------------------------------
  // Priority selection
  // ---------------------------------------------------------------
  logic [11:0] qual;                              // Qualifying requests
  logic        any_qual;
  logic [3:0]  win_lvl;
  logic        next_irq_pending, next_nmi_pending, next_irq;
  logic [15:0] next_vector_addr;

  // Lowest qualifying level wins; NMI overrides all maskables
  always_comb begin
    qual     = req & ~mask_flag & {12{global_enable_flag}};
    any_qual = |qual;
    win_lvl  = 4'h0;
    for (int i = irq_pkg::NUM_MASKABLE - 1; i >= 0; i--) begin
      if (qual[i]) begin
        win_lvl = 4'(i);
      end
    end
    next_nmi_pending = nmi_req & ~nmi_in_service_flag;
    next_irq_pending = any_qual | next_nmi_pending;
    if (next_nmi_pending) begin
      next_vector_addr = irq_pkg::VEC_NMI;
    end else if (any_qual) begin
      next_vector_addr = irq_pkg::VEC_TABLE[win_lvl];
    end else begin
      next_vector_addr = 16'h0000;
    end
    next_irq = |(stat & ~imask);
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_held, w_held;                   // Captured halves
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp, next_rresp;
  logic        do_write, do_read;
  logic [1:0]  next_ctrl;
  logic [3:0]  next_edge_sel, next_stat, next_imask, evt4;
  logic [11:0] next_req, next_mask_flag, clr_req;
  logic        next_nmi_req, next_nmi_in_service_flag, take, reti;

  // Decode bus traffic and update every flag
  always_comb begin
    next_aw_held = aw_held | (awvalid & awready);
    next_w_held  = w_held | (wvalid & wready);
    next_aw_addr = (awvalid & awready) ? awaddr : aw_addr;
    next_w_data  = (wvalid & wready) ? wdata : w_data;
    next_w_strb  = (wvalid & wready) ? wstrb : w_strb;
    do_write     = next_aw_held & next_w_held & ~bvalid;
    next_bvalid  = bvalid & ~bready;
    next_bresp   = bresp;
    next_ctrl = ctrl;
    next_edge_sel = edge_sel;
    next_mask_flag = mask_flag;
    next_imask = imask;
    clr_req = 12'h000;
    next_stat = stat;
    take = 1'b0;
    reti = 1'b0;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = irq_pkg::RESP_OKAY;
      case (next_aw_addr)
        irq_pkg::OFS_CTRL:  if (next_w_strb[0]) next_ctrl = next_w_data[1:0];
        irq_pkg::OFS_EDGE:  if (next_w_strb[0]) next_edge_sel = next_w_data[3:0];
        irq_pkg::OFS_REQ:   clr_req = next_w_data[11:0];
        irq_pkg::OFS_MASK:  next_mask_flag = next_w_data[11:0];
        irq_pkg::OFS_VECTOR: ;
        irq_pkg::OFS_ACK: begin
          take = next_w_data[irq_pkg::ACK_TAKE_BIT];
          reti = next_w_data[irq_pkg::ACK_RETI_BIT];
        end
        irq_pkg::OFS_STAT:  next_stat = stat & ~next_w_data[3:0];
        irq_pkg::OFS_IMASK: next_imask = next_w_data[3:0];
        default:            next_bresp = irq_pkg::RESP_SLVERR;
      endcase
    end
    // Taking the vector clears the served request; taking the NMI opens NMI service
    next_nmi_in_service_flag = nmi_in_service_flag;
    if (take && nmi_pending) begin
      next_nmi_in_service_flag = 1'b1;
      clr_req = 12'h000;
    end else if (take && irq_pending) begin
      clr_req = clr_req | (12'h001 << win_lvl);
    end
    if (reti) begin
      next_nmi_in_service_flag = 1'b0;
    end
    // Set wins over clear
    next_req = (req & ~clr_req) | raw_evt;
    next_nmi_req = (nmi_req & ~(take & nmi_pending))
                 | (periph_evt.watchdog_overflow_irq & wd_is_nmi);
    // Events: NMI raised, maskable raised, served, write bus error
    evt4 = {do_write & (next_bresp == irq_pkg::RESP_SLVERR), take & irq_pending,
            |raw_evt, periph_evt.watchdog_overflow_irq & wd_is_nmi};
    next_stat = next_stat | evt4;
    // Reads
    do_read    = arvalid & arready;
    next_rvalid = rvalid & ~rready;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp  = irq_pkg::RESP_OKAY;
      case (araddr)
        irq_pkg::OFS_CTRL:   next_rdata = {30'h0, ctrl};
        irq_pkg::OFS_EDGE:   next_rdata = {28'h0, edge_sel};
        irq_pkg::OFS_REQ:    next_rdata = {20'h0, req};
        irq_pkg::OFS_MASK:   next_rdata = {20'h0, mask_flag};
        irq_pkg::OFS_VECTOR: next_rdata = {irq_pending, nmi_pending, nmi_in_service_flag,
                                           13'h0, vector_addr};
        irq_pkg::OFS_ACK:    next_rdata = 32'h0;
        irq_pkg::OFS_STAT:   next_rdata = {28'h0, stat};
        irq_pkg::OFS_IMASK:  next_rdata = {28'h0, imask};
        default: begin
          next_rdata = 32'h0;
          next_rresp = irq_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Register all bus and control state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= 2'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
      ctrl      <= irq_pkg::CTRL_RESET;
      edge_sel  <= irq_pkg::EDGE_RESET;
      req       <= 12'h000;
      mask_flag <= irq_pkg::MASK_RESET;
      nmi_req   <= 1'b0;
      nmi_in_service_flag <= 1'b0;
      stat  <= 4'h0;
      imask <= 4'hF;
      irq_pending <= 1'b0;
      nmi_pending <= 1'b0;
      vector_addr <= 16'h0000;
      irq <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      awready <= ~next_aw_held & ~next_bvalid;
      wready  <= ~next_w_held & ~next_bvalid;
      arready <= ~next_rvalid & ~(arvalid & arready);
      ctrl      <= next_ctrl;
      edge_sel  <= next_edge_sel;
      req       <= next_req;
      mask_flag <= next_mask_flag;
      nmi_req   <= next_nmi_req;
      nmi_in_service_flag <= next_nmi_in_service_flag;
      stat  <= next_stat;
      imask <= next_imask;
      irq_pending <= next_irq_pending;
      nmi_pending <= next_nmi_pending;
      vector_addr <= next_vector_addr;
      irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_NMI_VEC: assert property (nmi_pending |-> vector_addr == 16'h0004)
    else $error("NMI vector wrong");
  AST_WD_NMI: assert property (periph_evt.watchdog_overflow_irq && wd_is_nmi
      && !nmi_in_service_flag |=> ##1 nmi_pending)
    else $error("watchdog NMI not raised");
  AST_WD_MASK: assert property (periph_evt.watchdog_overflow_irq && !wd_is_nmi
      |=> req[0])
    else $error("maskable watchdog not requested");
  AST_NO_GIE: assert property (!global_enable_flag && !nmi_req |=> !irq_pending)
    else $error("pending without enable");
  AST_REMOTE_RISE: assert property (rise_r |=> req[3])
    else $error("remote rise lost");
  AST_REMOTE_FALL: assert property (fall_r |=> req[4])
    else $error("remote fall lost");
  AST_PRIO: assert property (qual[6] && qual[11] && qual[5:0] == 6'h00
      && !next_nmi_pending |=> vector_addr == 16'h0010)
    else $error("priority order broken");
  AST_QUAL: assert property (irq_pending && !nmi_pending
      |-> $past(any_qual))
    else $error("unqualified request served");
  AST_WATCH: assert property (periph_evt.watch_interval_irq |=> req[11])
    else $error("watch interval lost");
  AST_BRESP: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  COV_NMI:  cover property (nmi_pending ##1 nmi_in_service_flag);
  COV_MASK: cover property (irq_pending && !nmi_pending);
  COV_TWO:  cover property ($countones(qual) > 1);
  COV_PIN:  cover property (pin_a_hit);

endmodule

//--- periph_model.sv
/*
  Model of the on-chip peripherals that feed the interrupt unit.
  Assumes the bench raises a command bit for one or more aclk cycles.
*/
module periph_model (
  input  wire logic                 aclk,
  input  wire irq_pkg::periph_evt_s cmd,
  output irq_pkg::periph_evt_s      periph_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  irq_pkg::periph_evt_s last;  // Command seen one cycle ago

  // ---------------------------------------------------------------
  // Event pulses
  // ---------------------------------------------------------------
  // Each new command bit leaves as exactly one aclk pulse, as real
  // peripherals emit their overflow, match and done strobes
  always_ff @(posedge aclk) begin
    periph_evt <= cmd & ~last;
    last       <= cmd;
  end
endmodule

//--- tb_top.sv
/*
  Self-checking bench for the vectored interrupt priority unit.
  Assumes the irq_pkg register map and the hand-over timing.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rd_d;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, irq_pending, nmi_pending, irq;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [31:0] rdata;
  logic [15:0] vector_addr;
  logic ext_pin_a = 0, ext_pin_b = 1, remote_pin = 0;
  irq_pkg::periph_evt_s cmd = '0, periph_evt;
  int mismatches = 0, n_compared = 0;
  int lvl [8] = '{0, 5, 6, 7, 8, 9, 10, 11};  // Level of each event bit, msb first

  always #2 aclk = ~aclk;  // 250 MHz

  periph_model pm (.aclk(aclk), .cmd(cmd), .periph_evt(periph_evt));
  vectored_interrupt_priority_unit uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .periph_evt(periph_evt), .ext_pin_a(ext_pin_a), .ext_pin_b(ext_pin_b),
    .remote_pin(remote_pin), .irq_pending(irq_pending), .nmi_pending(nmi_pending),
    .vector_addr(vector_addr), .irq(irq));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // AXI4-Lite write, each channel released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid && bready) bready <= 0;
      wr_r = bresp;
    end while (!(bvalid === 1'b1));
  endtask

  // AXI4-Lite read, data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      rd_d = rdata;
      rd_r = rresp;
    end while (!(rvalid === 1'b1));
    rready <= 0;
  endtask

  // Let a request settle, check its vector, then clear all request flags
  task automatic vec(input logic [15:0] exp);
    repeat (10) @(posedge aclk);
    chk("vector_addr", {16'h0000, vector_addr}, {16'h0000, exp});
    wr(irq_pkg::OFS_REQ, 32'h0000_0FFF);
  endtask

  // Single closing point
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    close_out();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    // Reset values of control, mask and line mask
    rd(irq_pkg::OFS_CTRL); chk("ctrl", rd_d, 32'h0000_0002);
    rd(irq_pkg::OFS_MASK); chk("mask", rd_d, 32'h0000_0FFF);
    rd(irq_pkg::OFS_IMASK); chk("imask", rd_d, 32'h0000_000F);
    // Watchdog as NMI is served with global enable off
    @(posedge aclk) cmd <= 8'h80;
    @(posedge aclk) cmd <= '0;
    vec(16'h0004);
    rd(irq_pkg::OFS_VECTOR); chk("vector reg", rd_d, 32'hC000_0004);
    wr(irq_pkg::OFS_ACK, 32'h0000_0001);
    @(posedge aclk);
    chk("nmi_pending", nmi_pending, 1'b0);
    rd(irq_pkg::OFS_VECTOR); chk("in service", rd_d, 32'h2000_0000);
    wr(irq_pkg::OFS_ACK, 32'h0000_0002);
    rd(irq_pkg::OFS_VECTOR); chk("service end", rd_d, 32'h0000_0000);
    // Interrupt line: unmasked and raised, then cleared
    wr(irq_pkg::OFS_IMASK, 32'h0); repeat (2) @(posedge aclk);
    chk("irq", irq, 1'b1);
    wr(irq_pkg::OFS_STAT, 32'hF); repeat (2) @(posedge aclk);
    chk("irq cleared", irq, 1'b0);
    // Every internal source maskable, one at a time
    wr(irq_pkg::OFS_CTRL, 32'h1);
    wr(irq_pkg::OFS_MASK, 32'h0);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk) cmd <= 8'h80 >> i;
      @(posedge aclk) cmd <= '0;
      repeat (4) @(posedge aclk);
      rd(irq_pkg::OFS_REQ); chk("req", rd_d, 32'h1 << lvl[i]);
      vec(16'h0004 + 16'(2 * lvl[i]));
    end
    // Simultaneous requests, masking and global enable
    @(posedge aclk) cmd <= 8'h21;
    @(posedge aclk) cmd <= '0;
    repeat (8) @(posedge aclk);
    chk("pri", {16'h0, vector_addr}, 32'h0010);
    wr(irq_pkg::OFS_MASK, 32'h040); repeat (3) @(posedge aclk);
    chk("masked", {16'h0, vector_addr}, 32'h001A);
    wr(irq_pkg::OFS_ACK, 32'h1);
    rd(irq_pkg::OFS_REQ);
    chk("taken", rd_d, 32'h040);
    wr(irq_pkg::OFS_MASK, 32'h0);
    repeat (3) @(posedge aclk);
    chk("unmasked", {16'h0, vector_addr}, 32'h0010);
    wr(irq_pkg::OFS_CTRL, 32'h0); repeat (3) @(posedge aclk);
    chk("gie off", irq_pending, 1'b0);
    wr(irq_pkg::OFS_REQ, 32'hFFF);
    wr(irq_pkg::OFS_CTRL, 32'h1);
    wr(irq_pkg::OFS_MASK, 32'h0);
    // Pin edges: a rising, b falling, then a on both edges
    wr(irq_pkg::OFS_EDGE, 32'h4);
    ext_pin_a <= 1; vec(16'h0006);
    ext_pin_a <= 0; vec(16'h0000);
    ext_pin_b <= 0; vec(16'h0008);
    remote_pin <= 1; vec(16'h000A);
    remote_pin <= 0; vec(16'h000C);
    wr(irq_pkg::OFS_EDGE, 32'h2);
    ext_pin_a <= 1; vec(16'h0006);
    ext_pin_a <= 0; vec(16'h0006);
    wr(irq_pkg::OFS_EDGE, 32'hF);
    ext_pin_a <= 1;
    vec(16'h0000);
    // Bus error response and its sticky status bit
    wr(irq_pkg::OFS_STAT, 32'hF);
    chk("bresp ok", {30'h0, wr_r}, {30'h0, irq_pkg::RESP_OKAY});
    wr(8'h20, 32'h0);
    chk("bresp", {30'h0, wr_r}, {30'h0, irq_pkg::RESP_SLVERR});
    rd(irq_pkg::OFS_STAT);
    chk("stat", rd_d, 32'h0000_0008);
    // Unmapped address
    rd(8'h20); chk("rresp", {30'h0, rd_r}, {30'h0, irq_pkg::RESP_SLVERR});
    chk("rdata", rd_d, 32'h0);
    close_out();
  end
endmodule
